//--- rtl/i2crd_pkg.sv
// Constants for the two-packet register read path over the serial bus
// Assumes a 200 MHz system clock and a bus clock pin used as a clock
// Function
// [RL1] Master sends address byte with write bit
// [RL2] Command byte 0 bits 2:0, 100b reads
// [RL3] Byte 2 bits 5:2 are byte enables
// [RL4] Byte 2 bits 1:0 give address 11:10
// [RL5] Byte 3 gives register address bits 9:2
// [RL6] Master reopens with address and read bit
// [RL7] Device returns bytes 31:24 first, 7:0 last
// [RL8] Device answers to address 68h by default
// [RL9] Inputs 7:5 at 000 give default address
// [RL10] Master frames each packet with START, STOP
// [RL11] Subsystem ids readable at byte offset F8h
// [RL12] Five-bit port select, ports 0 to 2
// [RL13] Address bits 1:0 always zero
// [RL14] Read command loads register into buffer
// [RL15] Reading past four bytes restarts at byte 3
// [RL16] Device acks address and command bytes
package i2crd_pkg;
  localparam logic [3:0]  SLV_ADDR_HI   = 4'hD;
  localparam int          STRAP_W       = 3;
  localparam logic [2:0]  OP_READ       = 3'h4;
  localparam int          OP_LSB        = 0;
  localparam int          PSEL_HI_LSB   = 0;
  localparam int          PSEL_LO_BIT   = 7;
  localparam int          BE_LSB        = 2;
  localparam int          ADDR_HI_LSB   = 0;
  localparam logic [11:0] OFS_SUBSYS    = 12'h0F8;
  localparam logic [4:0]  NUM_PORTS     = 5'h03;
  localparam logic [31:0] FILL_ZERO     = 32'h0;
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [1:0]  CMD_LAST      = 2'h3;
  localparam logic [1:0]  BYTE_MSB      = 2'h3;
  localparam logic [7:0]  NOT_READY     = 8'hFF;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD  = 2'b01,
    PH_TX   = 2'b10,
    PH_IDLE = 2'b11
  } i2crd_phase_t;
endpackage

//--- rtl/i2crd_top.sv
// Serial-bus slave that serves register reads from a command buffer
// Assumes open-drain bus outside; scl_clk is the bus clock pin
`timescale 1ns/1ps
module i2crd_top (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        scl_clk,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_n,
  input  wire logic [i2crd_pkg::STRAP_W-1:0] gpio_strap,
  input  wire logic [31:0]                 subsystem_ids_p0,
  input  wire logic [31:0]                 subsystem_ids_p1,
  input  wire logic [31:0]                 subsystem_ids_p2
);
  import i2crd_pkg::*;

  // System-domain pin sampling
  logic        scl_s1, scl_s2, sda_s1, sda_s2, sda_s3;
  logic        frame_rst_r;
  logic        link_rst_n;
  logic [STRAP_W-1:0] strap_s1, strap_s2, strap_r;
  logic        strap_done_r;
  logic [1:0]  strap_age_r;

  // Link-domain state
  i2crd_phase_t phase_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic        ack_r;
  logic [1:0]  cmd_idx_r;
  logic [7:0]  tx_r;
  logic [1:0]  tx_idx_r;
  logic [31:0] cmd_r;
  logic        cmd_tgl_r;
  logic        done_l1, done_l2;
  logic [STRAP_W-1:0] adr_l1, adr_l2;
  logic [7:0]  byte_in;
  logic [6:0]  slave_addr;
  logic        buf_ready;
  logic [7:0]  tx_pick;

  // System-domain command side
  logic        req_s1, req_s2, req_s3;
  logic        req_edge;
  logic        done_tgl_r;
  logic [31:0] buf_r;
  logic [2:0]  op;
  logic [4:0]  psel;
  logic [3:0]  be;
  logic [11:0] byte_addr;
  logic [31:0] reg_val;
  logic [31:0] reg_masked;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_clk;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // START or STOP holds the link logic in reset until the clock falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_rst_r <= 1'b1;
    end else if (scl_s2 && (sda_s3 != sda_s2)) begin
      frame_rst_r <= 1'b1;
    end else if (!scl_s2) begin
      frame_rst_r <= 1'b0;
    end
  end

  assign link_rst_n = nrst & ~frame_rst_r;

  // Address strap caught once after reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1     <= '0;
      strap_s2     <= '0;
      strap_r      <= '0;
      strap_done_r <= 1'b0;
      strap_age_r  <= 2'h0;
    end else begin
      strap_s1    <= gpio_strap;
      strap_s2    <= strap_s1;
      strap_age_r <= {strap_age_r[0], 1'b1};
      if (strap_age_r[1] && !strap_done_r) begin
        strap_r      <= strap_s2; // see [RL9]
        strap_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      adr_l1  <= '0;
      adr_l2  <= '0;
      done_l1 <= 1'b0;
      done_l2 <= 1'b0;
    end else begin
      adr_l1  <= strap_r;
      adr_l2  <= adr_l1;
      done_l1 <= done_tgl_r;
      done_l2 <= done_l1;
    end
  end

  assign slave_addr = {SLV_ADDR_HI, adr_l2}; // see [RL8] see [RL9]
  assign byte_in    = {sh_r[6:0], sda_i};
  assign buf_ready  = (done_l2 == cmd_tgl_r);
  assign tx_pick    = buf_ready ? buf_r[{tx_idx_r - 2'h1, 3'h0} +: 8] : NOT_READY;

  // Byte engine on the bus clock
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase_r   <= PH_ADDR;
      bit_r     <= '0;
      sh_r      <= '0;
      ack_r     <= 1'b0;
      cmd_idx_r <= '0;
      tx_r      <= '0;
      tx_idx_r  <= BYTE_MSB;
    end else if (bit_r != BIT_ACK) begin
      sh_r  <= byte_in;
      bit_r <= bit_r + 4'h1;
      if (bit_r == BIT_LAST) begin
        case (phase_r)
          PH_ADDR: begin
            ack_r <= (byte_in[7:1] == slave_addr); // see [RL8] see [RL16]
          end
          PH_CMD: begin
            ack_r <= 1'b1; // see [RL16]
          end
          default: begin
            ack_r <= 1'b0;
          end
        endcase
      end
    end else begin
      bit_r <= '0;
      ack_r <= 1'b0;
      case (phase_r)
        PH_ADDR: begin
          if (!ack_r) begin
            phase_r <= PH_IDLE;
          end else if (sh_r[0]) begin
            phase_r  <= PH_TX;
            tx_idx_r <= BYTE_MSB; // see [RL7]
            tx_r     <= buf_ready ? buf_r[31:24] : NOT_READY;
          end else begin
            phase_r   <= PH_CMD;
            cmd_idx_r <= '0;
          end
        end
        PH_CMD: begin
          cmd_idx_r <= cmd_idx_r + 2'h1;
          if (cmd_idx_r == CMD_LAST) begin
            phase_r <= PH_IDLE;
          end
        end
        PH_TX: begin
          if (sda_i) begin
            phase_r <= PH_IDLE;
          end else begin
            tx_idx_r <= tx_idx_r - 2'h1; // see [RL7] see [RL15]
            tx_r     <= tx_pick;
          end
        end
        default: begin
          phase_r <= PH_IDLE;
        end
      endcase
    end
  end

  // Command bytes held across the repeated start or stop
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_r     <= '0;
      cmd_tgl_r <= 1'b0;
    end else if (phase_r == PH_CMD && bit_r == BIT_LAST) begin
      cmd_r <= {cmd_r[23:0], byte_in};
      if (cmd_idx_r == CMD_LAST) begin
        cmd_tgl_r <= ~cmd_tgl_r; // see [RL14]
      end
    end
  end

  // Open-drain drive changes on the falling bus clock
  always_ff @(negedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe_n <= 1'b1;
    end else if (bit_r == BIT_ACK) begin
      sda_oe_n <= ~ack_r; // see [RL16]
    end else if (phase_r == PH_TX) begin
      sda_oe_n <= tx_r[~bit_r[2:0]]; // see [RL7]
    end else begin
      sda_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Command decode and register fetch
  assign op        = cmd_r[24 + OP_LSB +: 3];                            // see [RL2]
  assign psel      = {cmd_r[16 + PSEL_HI_LSB +: 4], cmd_r[8 + PSEL_LO_BIT]}; // see [RL12]
  assign be        = cmd_r[8 + BE_LSB +: 4];                              // see [RL3]
  assign byte_addr = {cmd_r[8 + ADDR_HI_LSB +: 2], cmd_r[7:0], 2'b00};   // see [RL4] see [RL5] see [RL13]

  always_comb begin
    reg_val = FILL_ZERO;
    if (byte_addr == OFS_SUBSYS && psel < NUM_PORTS) begin // see [RL11]
      case (psel[1:0])
        2'h0:    reg_val = subsystem_ids_p0;
        2'h1:    reg_val = subsystem_ids_p1;
        default: reg_val = subsystem_ids_p2;
      endcase
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_be
      assign reg_masked[gb*8 +: 8] = be[gb] ? reg_val[gb*8 +: 8] : 8'h00; // see [RL3]
    end
  endgenerate

  assign req_edge = req_s2 ^ req_s3;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_s1     <= 1'b0;
      req_s2     <= 1'b0;
      req_s3     <= 1'b0;
      done_tgl_r <= 1'b0;
      buf_r      <= FILL_ZERO;
    end else begin
      req_s1 <= cmd_tgl_r;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_edge) begin
        done_tgl_r <= req_s2;
        if (op == OP_READ) begin
          buf_r <= reg_masked; // see [RL14]
        end
      end
    end
  end

  a_buf_load_id: assert property (@(posedge clk) disable iff (!nrst)
    req_edge && op == OP_READ && psel == 5'h00 && byte_addr == OFS_SUBSYS && be == 4'hF
    |=> buf_r == $past(subsystem_ids_p0)) else $error("subsystem ids not buffered"); // see [RL11]
  a_bad_op_keep: assert property (@(posedge clk) disable iff (!nrst)
    req_edge && op != OP_READ |=> $stable(buf_r)) else $error("buffer changed on bad opcode"); // see [RL2]
  a_be_mask_top: assert property (@(posedge clk) disable iff (!nrst)
    req_edge && op == OP_READ && !be[3] |=> buf_r[31:24] == 8'h00) else $error("disabled byte not zero"); // see [RL3]
  a_port_range: assert property (@(posedge clk) disable iff (!nrst)
    req_edge && op == OP_READ && psel >= NUM_PORTS |=> buf_r == 32'h0) else $error("bad port returned data"); // see [RL12]
  a_addr_other: assert property (@(posedge clk) disable iff (!nrst)
    req_edge && op == OP_READ && byte_addr != OFS_SUBSYS |=> buf_r == 32'h0) else $error("unmapped address data"); // see [RL5]
  a_addr_ack: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
    phase_r == PH_ADDR && bit_r == BIT_LAST |=> ack_r == ($past(byte_in[7:1]) == slave_addr)) else $error("address ack wrong"); // see [RL8]
  a_cmd_ack: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
    phase_r == PH_CMD && bit_r == BIT_LAST |=> ack_r ##1 !ack_r) else $error("command byte not acked"); // see [RL16]
  a_tx_first: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
    phase_r == PH_ADDR && bit_r == BIT_ACK && ack_r && sh_r[0] |=> phase_r == PH_TX && tx_idx_r == BYTE_MSB)
    else $error("read did not start at top byte"); // see [RL7]
  a_tx_wrap: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
    phase_r == PH_TX && bit_r == BIT_ACK && !sda_i && tx_idx_r == 2'h0 |=> tx_idx_r == BYTE_MSB)
    else $error("read did not wrap"); // see [RL15]

  c_read_cmd: cover property (@(posedge clk) disable iff (!nrst) req_edge && op == OP_READ);
  c_tx_wrap: cover property (@(posedge scl_clk) disable iff (!link_rst_n)
    phase_r == PH_TX && bit_r == BIT_ACK && tx_idx_r == 2'h0 && !sda_i);
  c_tx_nack: cover property (@(posedge scl_clk) disable iff (!link_rst_n)
    phase_r == PH_TX && bit_r == BIT_ACK && sda_i);
endmodule // i2crd_top

//--- sim/i2crd_master.sv
// Serial bus master model: makes the bus clock only inside frames
// Assumes a pull-up on the data line, so a released line reads high
`timescale 1ns/1ps
module i2crd_master (
  output logic      scl_clk,
  output logic      sda_low,
  input  wire logic sda
);
  localparam time Q = 8ns;
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b0;
    #Q scl_clk = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl_clk = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q scl_clk = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
    #Q;
  endtask
  // Data changes only while the clock is low; sampled in mid-high
  task automatic xbit(input logic b, output logic r);
    sda_low = !b;
    #Q scl_clk = 1'b1;
    #Q r = sda;
    #Q scl_clk = 1'b0;
    #Q;
  endtask
  // MSB first; a = 0 acknowledges a read byte, 1 ends the read
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(a, k);
  endtask
endmodule // i2crd_master

//--- sim/tb_top.sv
// Testbench: two-packet register reads through the bus master model
// Assumes the device answers on the open-drain data line only
`timescale 1ns/1ps
module tb_top;
  import i2crd_pkg::*;
  logic        clk, nrst, scl_clk, sda_low, sda_o, sda_oe_n;
  logic [2:0]  gpio_strap;
  logic [31:0] ids0, ids1, ids2;
  wire         sda = !(sda_low || !sda_oe_n);
  int          n_fail, checks;
  i2crd_top i_dut (.clk(clk), .nrst(nrst), .scl_clk(scl_clk), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .gpio_strap(gpio_strap),
    .subsystem_ids_p0(ids0), .subsystem_ids_p1(ids1), .subsystem_ids_p2(ids2));
  i2crd_master i_mst (.scl_clk(scl_clk), .sda_low(sda_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Sends n bytes of s, MSB byte first; bad marks an address not ours
  task automatic cmd(input logic [47:0] s, input int n, input logic bad);
    logic [7:0] q;
    logic       k;
    i_mst.start();
    for (int i = 0; i < n; i++) begin
      i_mst.xbyte(s[(5-i)*8+:8], 1'b1, q, k);
      chk({31'h0, k}, {31'h0, bad || i == 5});
    end
    i_mst.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input int n);
    logic [7:0] q;
    logic       k;
    i_mst.start();
    i_mst.xbyte(a, 1'b1, q, k);
    chk({31'h0, k}, 32'h0);
    chk({31'h0, sda_o}, 32'h0);
    for (int j = 0; j < n; j++) begin
      i_mst.xbyte(8'hFF, j == n - 1, q, k);
      chk({24'h0, q}, {24'h0, exp[(3-j%4)*8+:8]});
    end
    i_mst.stop();
  endtask
  task automatic rst(input logic [2:0] s);
    @(negedge clk);
    nrst = 1'b0;
    gpio_strap = s;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
  endtask
  initial begin
    n_fail = 0;
    checks = 0;
    nrst = 1'b0;
    gpio_strap = 3'h0;
    ids0 = 32'h1234_5678;
    ids1 = 32'h9ABC_DEF0;
    ids2 = 32'h0F1E_2D3C;
    rst(3'h0);
    cmd(48'hD0_04_00_3C_3E_00, 5, 1'b0);
    rd(8'hD1, 32'h1234_5678, 6);
    @(negedge clk);
    ids0 = 32'hCAFE_F00D;
    rd(8'hD1, 32'h1234_5678, 4);
    $display("test walk and wrap done");
    cmd(48'hD0_04_00_BC_3E_00, 5, 1'b0);
    rd(8'hD1, ids1, 4);
    cmd(48'hD0_04_01_3C_3E_00, 5, 1'b0);
    rd(8'hD1, ids2, 4);
    cmd(48'hD0_03_00_3C_3E_00, 5, 1'b0);
    rd(8'hD1, ids2, 4);
    cmd(48'hD0_04_01_BC_3E_00, 5, 1'b0);
    rd(8'hD1, 32'h0, 4);
    $display("test port select done");
    cmd(48'hD0_04_00_0C_3E_00, 5, 1'b0);
    rd(8'hD1, 32'h0000_F00D, 4);
    cmd(48'hD0_04_00_20_3E_00, 5, 1'b0);
    rd(8'hD1, 32'hCA00_0000, 4);
    cmd(48'hD0_04_00_3D_3E_00, 5, 1'b0);
    rd(8'hD1, 32'h0, 4);
    cmd(48'hD0_04_00_3C_3D_00, 5, 1'b0);
    rd(8'hD1, 32'h0, 4);
    $display("test enables and address done");
    cmd(48'hD2_04_00_3C_3E_00, 5, 1'b1);
    cmd(48'hD0_04_00_3C_3E_00, 6, 1'b0);
    $display("test refusals done");
    rst(3'h5);
    cmd(48'hD0_04_00_3C_3E_00, 1, 1'b1);
    cmd(48'hDA_04_00_3C_3E_00, 5, 1'b0);
    rd(8'hDB, 32'hCAFE_F00D, 4);
    $display("test strap done");
    results();
  end
  initial begin
    #400us;
    n_fail++;
    results();
  end
endmodule // tb_top
